// ---- rtl/psl_pkg.sv ----
// Constants and types shared by the power switch and LED sequencer.
// Assumes a 10 MHz system clock; all long times run off a 1 ms tick.
package psl_pkg;
  // Clock period and the millisecond tick derived from it
  localparam int CLK_NS = 100;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = (TICK_NS + CLK_NS - 1) / CLK_NS;

  // Millisecond counter type and the times that it is compared with
  typedef logic [13:0] psl_ms_t;
  localparam psl_ms_t DEBOUNCE_MS = 14'h0014; // 20 ms
  localparam psl_ms_t HOLD_MS = 14'h07d0; // 2000 ms hold to power off
  localparam psl_ms_t SLOW_MS = 14'h1f40; // 8000 ms charge cycle
  localparam psl_ms_t SLOW_HALF_MS = 14'h0fa0; // 4000 ms
  localparam psl_ms_t SYNC_MS = 14'h07d0; // 2000 ms amber limit
  localparam psl_ms_t AMBER_MS = 14'h007d; // 125 ms, two flashes
  localparam psl_ms_t AMBER_ON_MS = 14'h001f; // 31 ms lit
  localparam psl_ms_t AMBER_HALF_MS = 14'h003e; // 62 ms
  localparam psl_ms_t HB_MS = 14'h2710; // 10000 ms heartbeat
  localparam psl_ms_t HB_ON_MS = 14'h0064; // 100 ms blink
  localparam psl_ms_t UP_MS = 14'h03fc; // 1020 ms fade
  localparam psl_ms_t DOWN_MS = 14'h0300; // three 256 ms flashes
  localparam psl_ms_t FAULT_MS = 14'h0100; // two 128 ms flashes
  localparam psl_ms_t SLEEP_MS = 14'h0100; // red then green
  localparam psl_ms_t WAKE_MS = 14'h0080; // one green flash

  // Brightness levels
  localparam logic [7:0] LVL_BRIGHT = 8'hff;
  localparam logic [7:0] LVL_DIM = 8'h14;
  localparam logic [7:0] LVL_AMBER_G = 8'h50;

  // Power control states
  typedef enum {PWR_OFF, PWR_ARM, PWR_ON, PWR_PRESS, PWR_DRAIN} psl_pwr_t;
  // Power LED event patterns
  typedef enum {PAT_NONE, PAT_FAULT, PAT_DOWN, PAT_UP, PAT_SLEEP,
                PAT_WAKE} psl_pat_t;
endpackage

// ---- rtl/psl_debounce.sv ----
// Button debouncer: the output follows the raw level once it has held
// for a number of millisecond ticks. Input is synchronous to clock_i.
`timescale 1ns/10ps
module psl_debounce #(
  parameter int CNT_W = 14
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic tick_i,
  input wire logic raw_i,
  output logic stable_o
);
  logic [CNT_W-1:0] cnt_reg; // Ticks the raw level has differed
  logic [CNT_W-1:0] cnt_next;
  logic stable_next;

  if (CNT_W < 5) begin : g_chk
    $error("psl_debounce: CNT_W too small");
  end

  // Count disagreeing ticks, flip once the count is reached
  always_comb begin
    cnt_next = cnt_reg;
    stable_next = stable_o;
    if (raw_i == stable_o) begin
      cnt_next = '0;
    end else if (tick_i) begin
      if (cnt_reg == CNT_W'(psl_pkg::DEBOUNCE_MS)) begin
        stable_next = raw_i;
        cnt_next = '0;
      end else begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
  end

  // Register the debounce state
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg <= '0;
      stable_o <= 1'b0;
    end else if (ce_i) begin
      cnt_reg <= cnt_next;
      stable_o <= stable_next;
    end
  end
endmodule

// ---- rtl/psl_pwm.sv ----
// Bank of pulse-width modulators, one per LED element, sharing one
// free-running counter. Outputs are registered.
`timescale 1ns/10ps
module psl_pwm #(
  parameter int N = 28,
  parameter int W = 8
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic [N*W-1:0] level_i,
  output logic [N-1:0] pwm_o
);
  logic [W-1:0] cnt_reg; // Shared ramp
  logic [W-1:0] cnt_next;
  logic [N-1:0] pwm_next;

  if (N < 1 || W < 2) begin : g_chk
    $error("psl_pwm: bad N or W");
  end

  // Duty is level/2^W, so light and current scale linearly (see RULE19)
  for (genvar i = 0; i < N; i++) begin : g_ch
    assign pwm_next[i] = level_i[i*W +: W] > cnt_reg;
  end
  assign cnt_next = cnt_reg + 1'b1;

  // Register ramp and outputs
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg <= '0;
      pwm_o <= '0;
    end else if (ce_i) begin
      cnt_reg <= cnt_next;
      pwm_o <= pwm_next;
    end
  end
endmodule

// ---- rtl/psl_top.sv ----
// Power switch and status LED sequencer for a battery powered node.
// Assumes synchronous status inputs, one-cycle event pulses, 10 MHz.
// Function
// (RULE1) Press while off powers on and boots
// (RULE2) Short press while on reboots
// (RULE3) Held press while on powers off
// (RULE4) Debounce; hold threshold splits short from held
// (RULE5) Power-up green fade; power-down three red flashes
// (RULE6) Charging awake: dim-bright green, eight seconds
// (RULE7) Charging asleep: off-dim green, eight seconds
// (RULE8) External power dim green; battery low dim red; code shows the dim green only while the processor is awake
// (RULE9) Power fault gives two short red flashes
// (RULE10) Fault input latched, pattern always completes
// (RULE11) Sleep entry: short red, short green
// (RULE12) Interrupt, alarm or tap: one green flash
// (RULE13) USB sync flashes amber sixteen per second
// (RULE14) Amber stops at two seconds or sync
// (RULE15) Basestation: green toggles per sent packet
// (RULE16) Basestation: red toggles per received packet
// (RULE17) Idle basestation: green blinks twice per ten seconds
// (RULE18) Eight RGB user LEDs, two user switches
// (RULE19) Eight-bit linear brightness per element
`timescale 1ns/10ps
module psl_top #(
  parameter int TICK_CYCLES = psl_pkg::TICK_CYCLES,
  parameter int USER_LEDS = 8,
  parameter int USER_SW = 2
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic button_i, // Control button, high when pressed
  input wire logic fault_i, // Supply monitor fault level
  input wire logic charging_i, // Battery is charging
  input wire logic ext_power_i, // External power present
  input wire logic cpu_asleep_i, // Processor asleep
  input wire logic batt_low_i, // Battery low
  input wire logic sleep_entry_i, // Pulse: processor enters sleep
  input wire logic wake_event_i, // Pulse: interrupt or alarm
  input wire logic usb_sync_start_i, // Pulse: USB sync attempt
  input wire logic usb_sync_done_i, // Pulse: sync complete
  input wire logic base_mode_i, // Basestation operation
  input wire logic pkt_tx_i, // Pulse: packet sent to host
  input wire logic pkt_rx_i, // Pulse: radio packet forwarded
  input wire logic [USER_LEDS*24-1:0] user_level_i, // R,G,B per LED
  input wire logic [USER_SW-1:0] user_sw_i,
  output logic power_on_o, // Unit supply enable
  output logic reboot_o, // One-cycle reboot request
  output logic pwr_led_r_o,
  output logic pwr_led_g_o,
  output logic act_led_r_o,
  output logic act_led_g_o,
  output logic [USER_LEDS*3-1:0] user_led_o, // Index 3*i+{0,1,2}=R,G,B
  output logic [USER_SW-1:0] user_sw_o
);
  localparam int TW = $clog2(TICK_CYCLES);
  localparam int NCH = 4 + USER_LEDS * 3;

  if (TICK_CYCLES < 2 || USER_LEDS < 1 || USER_SW < 1) begin : g_chk
    $error("psl_top: bad parameter");
  end

  // Millisecond tick
  logic [TW-1:0] tick_cnt_reg;
  logic [TW-1:0] tick_cnt_next;
  logic tick_reg; // One-cycle pulse every millisecond
  logic tick_next;

  always_comb begin
    tick_next = 1'b0;
    tick_cnt_next = tick_cnt_reg + 1'b1;
    if (tick_cnt_reg == TW'(TICK_CYCLES - 1)) begin
      tick_cnt_next = '0;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else if (ce_i) begin
      tick_cnt_reg <= tick_cnt_next;
      tick_reg <= tick_next;
    end
  end

  // Debounced button level (see RULE4)
  logic btn;
  psl_debounce #(.CNT_W(14)) u_deb (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .tick_i(tick_reg),
    .raw_i(button_i),
    .stable_o(btn)
  );

  // Power control state
  psl_pkg::psl_pwr_t pwr_reg, pwr_next;
  logic btn_q_reg, power_on_next, reboot_next;
  psl_pkg::psl_ms_t held_ms_reg, held_ms_next; // Press duration
  logic up_ev, down_ev, tap_ev; // Pattern requests
  logic btn_rise, btn_fall;

  assign btn_rise = btn & ~btn_q_reg;
  assign btn_fall = ~btn & btn_q_reg;

  // Power state machine
  always_comb begin
    pwr_next = pwr_reg;
    power_on_next = power_on_o;
    reboot_next = 1'b0;
    held_ms_next = held_ms_reg;
    up_ev = 1'b0;
    down_ev = 1'b0;
    tap_ev = 1'b0;
    unique case (pwr_reg)
      psl_pkg::PWR_OFF: begin
        if (btn_rise) begin // Power on and boot (see RULE1)
          pwr_next = psl_pkg::PWR_ARM;
          power_on_next = 1'b1;
          up_ev = 1'b1;
        end
      end
      psl_pkg::PWR_ARM: begin
        // Boot press must be released before it counts again
        if (!btn) pwr_next = psl_pkg::PWR_ON;
      end
      psl_pkg::PWR_ON: begin
        if (btn_rise) begin
          pwr_next = psl_pkg::PWR_PRESS;
          held_ms_next = '0;
        end
      end
      psl_pkg::PWR_PRESS: begin
        if (held_ms_reg == psl_pkg::HOLD_MS) begin // see RULE3 RULE4
          pwr_next = psl_pkg::PWR_DRAIN;
          power_on_next = 1'b0;
          down_ev = 1'b1;
        end else if (btn_fall) begin // Short press acts at release
          pwr_next = psl_pkg::PWR_ON;
          reboot_next = 1'b1; // see RULE2
          tap_ev = 1'b1; // see RULE12
        end else if (tick_reg) begin
          held_ms_next = held_ms_reg + 1'b1;
        end
      end
      psl_pkg::PWR_DRAIN: begin
        // Off, waiting for the hold to end so it cannot re-boot
        if (!btn) pwr_next = psl_pkg::PWR_OFF;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pwr_reg <= psl_pkg::PWR_OFF;
      btn_q_reg <= 1'b0;
      power_on_o <= 1'b0;
      reboot_o <= 1'b0;
      held_ms_reg <= '0;
    end else if (ce_i) begin
      pwr_reg <= pwr_next;
      btn_q_reg <= btn;
      power_on_o <= power_on_next;
      reboot_o <= reboot_next;
      held_ms_reg <= held_ms_next;
    end
  end

  // Power LED patterns; pending bits: 0 fault, 1 down, 2 up, 3 sleep,
  // 4 wake. Lower index wins; an event never clears its own bit.
  psl_pkg::psl_pat_t pat_reg, pat_next;
  psl_pkg::psl_ms_t pat_ms_reg, pat_ms_next;
  logic [4:0] pend_reg, pend_next, pend_clr, pend_set;
  logic fault_q_reg;
  psl_pkg::psl_ms_t pat_len;

  // Length of the running pattern
  always_comb begin
    unique case (pat_reg)
      psl_pkg::PAT_FAULT: pat_len = psl_pkg::FAULT_MS;
      psl_pkg::PAT_DOWN: pat_len = psl_pkg::DOWN_MS;
      psl_pkg::PAT_UP: pat_len = psl_pkg::UP_MS;
      psl_pkg::PAT_SLEEP: pat_len = psl_pkg::SLEEP_MS;
      psl_pkg::PAT_WAKE: pat_len = psl_pkg::WAKE_MS;
      psl_pkg::PAT_NONE: pat_len = '0;
    endcase
  end

  // Latch events, start the highest pending pattern when idle
  always_comb begin
    pend_set = {tap_ev | wake_event_i, sleep_entry_i, up_ev, down_ev,
                fault_i & ~fault_q_reg}; // see RULE10
    pend_clr = '0;
    pat_next = pat_reg;
    pat_ms_next = pat_ms_reg;
    if (pat_reg != psl_pkg::PAT_NONE) begin
      if (pat_ms_reg >= pat_len) pat_next = psl_pkg::PAT_NONE;
      else if (tick_reg) pat_ms_next = pat_ms_reg + 1'b1;
    end else begin
      pat_ms_next = '0;
      if (pend_reg[0]) begin
        pat_next = psl_pkg::PAT_FAULT;
        pend_clr = 5'h01;
      end else if (pend_reg[1]) begin
        pat_next = psl_pkg::PAT_DOWN;
        pend_clr = 5'h02;
      end else if (pend_reg[2]) begin
        pat_next = psl_pkg::PAT_UP;
        pend_clr = 5'h04;
      end else if (pend_reg[3]) begin
        pat_next = psl_pkg::PAT_SLEEP;
        pend_clr = 5'h08;
      end else if (pend_reg[4]) begin
        pat_next = psl_pkg::PAT_WAKE;
        pend_clr = 5'h10;
      end
    end
    pend_next = (pend_reg & ~pend_clr) | pend_set;
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pat_reg <= psl_pkg::PAT_NONE;
      pat_ms_reg <= '0;
      pend_reg <= '0;
      fault_q_reg <= 1'b0;
    end else if (ce_i) begin
      pat_reg <= pat_next;
      pat_ms_reg <= pat_ms_next;
      pend_reg <= pend_next;
      fault_q_reg <= fault_i;
    end
  end

  // Eight-second charge cycle counter
  psl_pkg::psl_ms_t slow_ms_reg, slow_ms_next;
  psl_pkg::psl_ms_t tri_ms; // Rises 0..4000 and falls back
  logic [15:0] ramp_prod;

  always_comb begin
    slow_ms_next = slow_ms_reg;
    if (tick_reg) begin
      if (slow_ms_reg == psl_pkg::SLOW_MS - 1'b1) slow_ms_next = '0;
      else slow_ms_next = slow_ms_reg + 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) slow_ms_reg <= '0;
    else if (ce_i) slow_ms_reg <= slow_ms_next;
  end

  assign tri_ms = (slow_ms_reg < psl_pkg::SLOW_HALF_MS) ? slow_ms_reg :
                  psl_pkg::SLOW_MS - slow_ms_reg;

  // Power LED levels: event pattern first, then steady state
  logic [7:0] pwr_r_lvl, pwr_g_lvl;

  always_comb begin
    pwr_r_lvl = '0;
    pwr_g_lvl = '0;
    ramp_prod = '0;
    unique case (pat_reg)
      psl_pkg::PAT_FAULT: begin
        if (!pat_ms_reg[6]) pwr_r_lvl = psl_pkg::LVL_BRIGHT; // see RULE9
      end
      psl_pkg::PAT_DOWN: begin
        if (!pat_ms_reg[7]) pwr_r_lvl = psl_pkg::LVL_BRIGHT; // see RULE5
      end
      psl_pkg::PAT_UP: begin
        // Sharp on, then a linear fade (see RULE5)
        pwr_g_lvl = psl_pkg::LVL_BRIGHT - pat_ms_reg[9:2];
      end
      psl_pkg::PAT_SLEEP: begin
        if (!pat_ms_reg[7]) pwr_r_lvl = psl_pkg::LVL_BRIGHT; // see RULE11
        else pwr_g_lvl = psl_pkg::LVL_BRIGHT;
      end
      psl_pkg::PAT_WAKE: begin
        pwr_g_lvl = psl_pkg::LVL_BRIGHT; // see RULE12
      end
      psl_pkg::PAT_NONE: begin
        if (!power_on_o) begin
          pwr_g_lvl = '0;
        end else if (batt_low_i) begin
          pwr_r_lvl = psl_pkg::LVL_DIM; // see RULE8
        end else if (charging_i && !cpu_asleep_i) begin
          // Dim to bright and back (see RULE6)
          ramp_prod = tri_ms[11:4] *
                      (psl_pkg::LVL_BRIGHT - psl_pkg::LVL_DIM);
          pwr_g_lvl = psl_pkg::LVL_DIM + ramp_prod[15:8];
        end else if (charging_i) begin
          // Off to dim and back (see RULE7)
          ramp_prod = tri_ms[11:4] * psl_pkg::LVL_DIM;
          pwr_g_lvl = ramp_prod[15:8];
        end else if (ext_power_i && !cpu_asleep_i) begin
          pwr_g_lvl = psl_pkg::LVL_DIM; // see RULE8
        end
      end
    endcase
  end

  // Activity LED state
  logic sync_reg, sync_next;
  psl_pkg::psl_ms_t sync_ms_reg, sync_ms_next; // Time since sync start
  psl_pkg::psl_ms_t amb_ms_reg, amb_ms_next; // Position in 125 ms
  logic tog_g_reg, tog_g_next, tog_r_reg, tog_r_next;
  psl_pkg::psl_ms_t hb_ms_reg, hb_ms_next;
  logic seen_reg, seen_next, quiet_reg, quiet_next;

  always_comb begin
    sync_next = sync_reg;
    sync_ms_next = sync_ms_reg;
    amb_ms_next = amb_ms_reg;
    tog_g_next = tog_g_reg;
    tog_r_next = tog_r_reg;
    hb_ms_next = hb_ms_reg;
    seen_next = seen_reg | pkt_tx_i | pkt_rx_i;
    quiet_next = quiet_reg & ~(pkt_tx_i | pkt_rx_i);
    // Amber sync window (see RULE13 RULE14)
    if (usb_sync_done_i) begin
      sync_next = 1'b0;
    end else if (usb_sync_start_i) begin
      sync_next = 1'b1;
      sync_ms_next = '0;
      amb_ms_next = '0;
    end else if (sync_reg && tick_reg) begin
      if (sync_ms_reg == psl_pkg::SYNC_MS - 1'b1) sync_next = 1'b0;
      sync_ms_next = sync_ms_reg + 1'b1;
      if (amb_ms_reg == psl_pkg::AMBER_MS - 1'b1) amb_ms_next = '0;
      else amb_ms_next = amb_ms_reg + 1'b1;
    end
    // Basestation packet toggles
    if (base_mode_i) begin
      if (pkt_tx_i) tog_g_next = ~tog_g_reg; // see RULE15
      if (pkt_rx_i) tog_r_next = ~tog_r_reg; // see RULE16
    end
    // Heartbeat interval; quiet if no packet in the last one
    if (!base_mode_i) begin
      hb_ms_next = '0;
      seen_next = 1'b0;
      quiet_next = 1'b0;
    end else if (tick_reg) begin
      if (hb_ms_reg == psl_pkg::HB_MS - 1'b1) begin
        hb_ms_next = '0;
        quiet_next = ~seen_next; // see RULE17
        seen_next = pkt_tx_i | pkt_rx_i;
      end else begin
        hb_ms_next = hb_ms_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync_reg <= 1'b0;
      sync_ms_reg <= '0;
      amb_ms_reg <= '0;
      tog_g_reg <= 1'b0;
      tog_r_reg <= 1'b0;
      hb_ms_reg <= '0;
      seen_reg <= 1'b0;
      quiet_reg <= 1'b0;
    end else if (ce_i) begin
      sync_reg <= sync_next;
      sync_ms_reg <= sync_ms_next;
      amb_ms_reg <= amb_ms_next;
      tog_g_reg <= tog_g_next;
      tog_r_reg <= tog_r_next;
      hb_ms_reg <= hb_ms_next;
      seen_reg <= seen_next;
      quiet_reg <= quiet_next;
    end
  end

  // Activity LED levels: two 31 ms flashes per 125 ms while syncing
  logic amber_on, hb_blink;
  logic [7:0] act_r_lvl, act_g_lvl;

  assign amber_on = sync_reg && (amb_ms_reg < psl_pkg::AMBER_ON_MS ||
    (amb_ms_reg >= psl_pkg::AMBER_HALF_MS && amb_ms_reg <
     psl_pkg::AMBER_HALF_MS + psl_pkg::AMBER_ON_MS)); // see RULE13
  assign hb_blink = quiet_reg && (hb_ms_reg < psl_pkg::HB_ON_MS ||
    (hb_ms_reg >= 2 * psl_pkg::HB_ON_MS &&
     hb_ms_reg < 3 * psl_pkg::HB_ON_MS)); // see RULE17
  assign act_r_lvl = amber_on ? psl_pkg::LVL_BRIGHT :
    (!sync_reg && base_mode_i && tog_r_reg) ? psl_pkg::LVL_BRIGHT : '0;
  assign act_g_lvl = amber_on ? psl_pkg::LVL_AMBER_G :
    (!sync_reg && base_mode_i && (tog_g_reg ^ hb_blink)) ?
    psl_pkg::LVL_BRIGHT : '0;

  // All LED elements share one modulator bank (see RULE18 RULE19)
  logic [NCH-1:0] pwm;
  psl_pwm #(.N(NCH), .W(8)) u_pwm (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .level_i({user_level_i, act_g_lvl, act_r_lvl, pwr_g_lvl,
              pwr_r_lvl}),
    .pwm_o(pwm)
  );
  assign pwr_led_r_o = pwm[0];
  assign pwr_led_g_o = pwm[1];
  assign act_led_r_o = pwm[2];
  assign act_led_g_o = pwm[3];
  assign user_led_o = pwm[NCH-1:4];

  // User switches registered for software (see RULE18)
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) user_sw_o <= '0;
    else if (ce_i) user_sw_o <= user_sw_i;
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  a_boot_press: assert property ( // see RULE1
    ce_i && pwr_reg == psl_pkg::PWR_OFF && btn_rise |=> power_on_o
    ##0 pend_reg[2]) else $error("press while off did not boot");
  a_short_reboot: assert property ( // see RULE2
    ce_i && pwr_reg == psl_pkg::PWR_PRESS && btn_fall &&
    held_ms_reg < psl_pkg::HOLD_MS |=> reboot_o && power_on_o)
    else $error("short press did not reboot");
  a_hold_off: assert property ( // see RULE3
    ce_i && pwr_reg == psl_pkg::PWR_PRESS &&
    held_ms_reg == psl_pkg::HOLD_MS |=> !power_on_o && !reboot_o)
    else $error("held press did not power off");
  a_reboot_pulse: assert property ( // see RULE4
    ce_i && reboot_o |=> !reboot_o)
    else $error("reboot longer than a cycle");
  a_fault_latch: assert property ( // see RULE10
    ce_i && fault_i && !fault_q_reg |=> pend_reg[0] ||
    pat_reg == psl_pkg::PAT_FAULT) else $error("fault event lost");
  a_fault_red: assert property ( // see RULE9
    pat_reg == psl_pkg::PAT_FAULT && pat_ms_reg < 14'h0040 |->
    pwr_r_lvl == psl_pkg::LVL_BRIGHT && pwr_g_lvl == 8'h00)
    else $error("fault flash not bright red");
  a_sync_stop: assert property ( // see RULE14
    ce_i && usb_sync_done_i |=> !sync_reg && !amber_on)
    else $error("amber kept flashing after sync");
  a_sync_bound: assert property ( // see RULE14
    sync_reg |-> sync_ms_reg < psl_pkg::SYNC_MS)
    else $error("amber exceeded two seconds");
  a_tx_toggle: assert property ( // see RULE15
    ce_i && base_mode_i && pkt_tx_i |=> tog_g_reg != $past(tog_g_reg))
    else $error("green did not toggle on send");
  a_rx_toggle: assert property ( // see RULE16
    ce_i && base_mode_i && pkt_rx_i |=> tog_r_reg != $past(tog_r_reg))
    else $error("red did not toggle on receive");
endmodule

// ---- sim/psl_btn_model.sv ----
// Partner model: a push button whose contacts chatter on each change.
// Assumes press_i is driven by the bench on rising clock edges.
`timescale 1ns/10ps
module psl_btn_model (
  input wire logic clock_i,
  input wire logic press_i, // Finger on the button
  output logic button_o // Contact level seen by the sequencer
);
  logic last_reg = 1'b0; // Finger level one cycle ago
  logic level_reg = 1'b0; // Contact level, single driver of button_o
  int bounce_cnt = 0; // Chatter cycles left
  // Contacts chatter for six cycles, then settle on the finger level
  always @(posedge clock_i) begin
    last_reg <= press_i;
    if (press_i !== last_reg) begin
      bounce_cnt <= 6;
    end else if (bounce_cnt > 0) begin
      bounce_cnt <= bounce_cnt - 1;
    end
    level_reg <= (bounce_cnt > 0) ? ~level_reg : press_i;
  end
  assign button_o = level_reg;
endmodule

// ---- sim/psl_top_bench.sv ----
// Bench for the power switch and LED sequencer, ms tick cut to 4 clocks.
// Assumes the button partner model and a 10 MHz clock.
`timescale 1ns/10ps
module psl_top_bench;
  localparam int TK = 4; // Clocks per ms tick
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic press = 1'b0; // Finger level
  logic button, fault, chg, ext, asleep, low, slp, wake, sy0, sy1;
  logic base, tx, rx, pon, rbt, pr, pg, ar, ag;
  logic [191:0] lvl; // User LED levels
  logic [1:0] sw, sw_o;
  logic [23:0] uled;
  logic [27:0] mon; // All LED lines: 0 ar, 1 ag, 2 pr, 3 pg, 4+ user
  int error_cnt, n_checks, rb_cnt, cyc;
  assign mon = {uled, pg, pr, ag, ar};
  always #50 clock_i = ~clock_i;
  psl_btn_model btn (.clock_i(clock_i), .press_i(press), .button_o(button));
  psl_top #(.TICK_CYCLES(TK)) uut (.clock_i(clock_i), .nrst_i(nrst_i),
    .ce_i(1'b1), .button_i(button), .fault_i(fault), .charging_i(chg),
    .ext_power_i(ext), .cpu_asleep_i(asleep), .batt_low_i(low),
    .sleep_entry_i(slp), .wake_event_i(wake), .usb_sync_start_i(sy0),
    .usb_sync_done_i(sy1), .base_mode_i(base), .pkt_tx_i(tx),
    .pkt_rx_i(rx), .user_level_i(lvl), .user_sw_i(sw),
    .power_on_o(pon), .reboot_o(rbt), .pwr_led_r_o(pr), .pwr_led_g_o(pg),
    .act_led_r_o(ar), .act_led_g_o(ag), .user_led_o(uled),
    .user_sw_o(sw_o));
  // Count reboot pulses and cut a hang short; mid-cycle, so tasks that
  // poll rb_cnt after a rising edge never race this counter
  always @(negedge clock_i) begin
    cyc++;
    if (rbt === 1'b1) rb_cnt++;
    if (cyc == 90000) begin
      error_cnt++;
      complete_run;
    end
  end
  task automatic complete_run;
    $display("errors %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input bit ok, input string m);
    n_checks++;
    if (!ok) begin
      error_cnt++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic ms(input int n);
    repeat (n * TK) @(posedge clock_i);
  endtask
  // High cycles of one LED line over a window, sampled mid-cycle; ends on
  // a rising edge so that the caller's next drive lands on the edge
  task automatic hi(input int i, input int len, output int n);
    n = 0;
    repeat (len) begin
      @(negedge clock_i);
      n += (mon[i] === 1'b1);
    end
    @(posedge clock_i);
  endtask
  task automatic t_user;
    int n;
    @(posedge clock_i) lvl[23:0] <= 24'hff0080;
    sw <= 2'h2;
    ms(1);
    chk(sw_o === 2'h2, "switch");
    hi(4, 256, n);
    chk(n == 128, "red level");
    hi(5, 256, n);
    chk(n == 0, "green level");
    hi(6, 256, n);
    chk(n == 255, "blue level");
  endtask
  task automatic t_on;
    int n;
    @(posedge clock_i) press <= 1'b1;
    for (n = 0; n < 200 && pon !== 1'b1; n++) @(posedge clock_i);
    chk(pon === 1'b1, "no power on");
    chk(n >= 80, "no debounce");
    hi(3, 256, n);
    chk(n >= 230, "no up pulse");
    @(posedge clock_i) press <= 1'b0;
    ms(40);
    chk(rb_cnt == 0, "boot release rebooted");
  endtask
  task automatic t_steady;
    int n;
    ms(1100);
    ext <= 1'b1;
    ms(2);
    hi(3, 256, n);
    chk(n >= 19 && n <= 21, "ext dim green");
    ext <= 1'b0;
    low <= 1'b1;
    ms(2);
    hi(2, 256, n);
    chk(n >= 19 && n <= 21, "low dim red");
    low <= 1'b0;
  endtask
  task automatic t_charge;
    int n, lo, up;
    lo = 999;
    up = 0;
    chg <= 1'b1;
    ext <= 1'b1;
    repeat (4) begin
      ms(2000);
      hi(3, 256, n);
      if (n < lo) lo = n;
      if (n > up) up = n;
    end
    chk(lo >= 18 && up - lo > 150, "charge swing");
    asleep <= 1'b1;
    ms(2);
    hi(3, 256, n);
    chk(n <= 21, "asleep charge");
    {chg, ext, asleep} <= 3'h0;
    ms(2);
  endtask
  // First window at ms 0-63 of a pattern, second at ms 128-191
  task automatic t_pat(input int i0, input int i1, input bit on1,
                       input string m);
    int n;
    hi(i0, 256, n);
    chk(n >= 248, m);
    ms(64);
    hi(i1, 256, n);
    chk(on1 ? n >= 248 : n < 10, m);
    ms(100);
  endtask
  task automatic t_events;
    @(posedge clock_i) fault <= 1'b1;
    @(posedge clock_i) fault <= 1'b0;
    t_pat(2, 2, 1, "fault flashes");
    @(posedge clock_i) slp <= 1'b1;
    @(posedge clock_i) slp <= 1'b0;
    t_pat(2, 3, 1, "sleep flashes");
    @(posedge clock_i) wake <= 1'b1;
    @(posedge clock_i) wake <= 1'b0;
    t_pat(3, 3, 0, "wake flash");
  endtask
  task automatic t_tap;
    int n;
    n = rb_cnt;
    @(posedge clock_i) press <= 1'b1;
    ms(40);
    press <= 1'b0;
    for (int k = 0; k < 200 && rb_cnt == n; k++) @(posedge clock_i);
    chk(rb_cnt == n + 1 && pon === 1'b1, "tap reboot");
    hi(3, 256, n);
    chk(n >= 248, "tap flash");
    ms(100);
  endtask
  task automatic t_sync;
    int n;
    @(posedge clock_i) sy0 <= 1'b1;
    @(posedge clock_i) sy0 <= 1'b0;
    ms(5);
    sy1 <= 1'b1;
    @(posedge clock_i) sy1 <= 1'b0;
    ms(1);
    hi(0, 256, n);
    chk(n == 0, "done kept amber");
    @(posedge clock_i) sy0 <= 1'b1;
    @(posedge clock_i) sy0 <= 1'b0;
    hi(0, 4000, n);
    chk(n >= 1950 && n <= 1990, "amber rate");
    ms(1100);
    hi(0, 256, n);
    chk(n == 0, "amber too long");
  endtask
  task automatic t_pkt(input int i, input int want, input string m);
    int n;
    @(posedge clock_i) {tx, rx} <= (i == 1) ? 2'h2 : 2'h1;
    @(posedge clock_i) {tx, rx} <= 2'h0;
    ms(1);
    hi(i, 256, n);
    chk(want ? n >= 248 : n == 0, m);
  endtask
  task automatic t_base;
    base <= 1'b1;
    t_pkt(1, 1, "tx toggle on");
    t_pkt(0, 1, "rx toggle on");
    t_pkt(1, 0, "tx toggle off");
    base <= 1'b0;
  endtask
  task automatic t_off;
    int n;
    n = rb_cnt;
    @(posedge clock_i) press <= 1'b1;
    for (int k = 0; k < 2200 * TK && pon !== 1'b0; k++) @(posedge clock_i);
    chk(pon === 1'b0 && rb_cnt == n, "hold power off");
    t_pat(2, 2, 0, "down flashes");
    press <= 1'b0;
    ms(40);
  endtask
  initial begin
    {fault, chg, ext, asleep, low, slp, wake, sy0, sy1, base, tx, rx} = '0;
    lvl = '0;
    sw = '0;
    repeat (16) @(posedge clock_i);
    nrst_i <= 1'b1;
    t_user;
    t_on;
    t_steady;
    t_charge;
    t_events;
    t_tap;
    t_sync;
    t_base;
    t_off;
    complete_run;
  end
endmodule
